// ### hw/cieu_pkg.sv
package cieu_pkg;

  // processor register image; all but h pushed on entry (low byte of pc first)
  localparam int NUM_SRC = 8;
  localparam logic [7:0] COND_RESET = 8'h68;    // mask bit set, fixed ones
  localparam int COND_MASK_BIT = 3;
  localparam logic [7:0] OPC_WAIT = 8'h8f;
  localparam logic [7:0] OPC_TRAP = 8'h83;
  localparam logic [15:0] VEC_TRAP = 16'hfffc;
  localparam logic [15:0] VEC_BASE = 16'hffe0;  // source n at base minus 2n
  localparam logic [15:0] SP_RESET = 16'h00ff;
  localparam int STACK_BYTES = 5;
  localparam int QUEUE_BYTES = 3;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic        free;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } cieu_bus_t;

  typedef struct packed {
    logic [15:0] pc;
    logic [7:0]  a;
    logic [7:0]  x;
    logic [7:0]  h;
  } cieu_regs_t;

endpackage

// ### hw/cieu_prio_enc.sv
`timescale 1ns/100ps
module cieu_prio_enc #(
  parameter int N = 8
) (
  input wire logic [N-1:0] i_req,         // qualified requests
  output logic o_any,                     // any request
  output logic [$clog2(N)-1:0] o_idx      // winning index
);
  // lowest index wins
  always_comb
  begin
    o_any = 1'b0;
    o_idx = '0;
    for (int i = N - 1; i >= 0; i--)
    begin
      if (i_req[i])
      begin
        o_any = 1'b1;
        o_idx = i[$clog2(N)-1:0];
      end
    end
  end
endmodule // cieu_prio_enc

// ### hw/cieu_entry.sv
`timescale 1ns/100ps
module cieu_entry #(
  parameter int NUM_SRC = cieu_pkg::NUM_SRC
) (
  input wire logic i_clk_sys,                       // bus clock
  input wire logic i_nrst,                          // async reset, low
  input wire logic [NUM_SRC-1:0] i_src_event,       // one-cycle source events
  input wire logic [NUM_SRC-1:0] i_src_enable,      // local enables
  input wire logic [NUM_SRC-1:0] i_src_flag_clr,    // flag clear strobes
  input wire logic i_instr_done,                    // core: instruction boundary
  input wire logic i_exec_wait,                     // core: wait opcode decoded
  input wire logic i_exec_trap,                     // core: software trap decoded
  input wire logic i_dbg_trap,                      // debug module forces trap
  input wire logic i_cond_load,                     // core: load condition code
  input wire logic [7:0] i_cond_value,              // value to load (stacked copy)
  input wire cieu_pkg::cieu_regs_t i_regs,          // registers to stack
  input wire logic [7:0] i_rdata,                   // read data
  output cieu_pkg::cieu_bus_t o_bus,                // bus cycle
  output logic [NUM_SRC-1:0] o_src_flag,            // pending flags
  output logic [7:0] o_condition_code_reg,          // condition code
  output logic [15:0] o_sp,                         // stack pointer
  output logic [15:0] o_pc,                         // new program counter
  output logic [23:0] o_queue,                      // instruction queue
  output logic o_busy,                              // sequencer owns bus
  output logic o_halted,                            // waiting for interrupt
  output logic o_entry_done                         // one-cycle entry end
);
  typedef enum {ST_RUN, ST_WAIT_FREE, ST_HALT, ST_WAIT_FETCH, ST_PUSH, ST_VEC_HI,
                ST_VEC_LO, ST_FILL} cieu_state_t;

  cieu_state_t state_reg;
  logic [NUM_SRC-1:0] flag_reg;
  logic [7:0] cond_reg;
  logic [15:0] sp_reg;
  logic [15:0] pc_reg;
  logic [15:0] vec_reg;
  logic [23:0] queue_reg;
  logic [2:0] cnt_reg;
  logic any_q;
  logic [$clog2(NUM_SRC)-1:0] win_idx;
  logic [NUM_SRC-1:0] qual;
  logic mask;
  logic take_hw;
  logic take_sw;
  logic [7:0] push_byte;

  assign mask = cond_reg[cieu_pkg::COND_MASK_BIT];
  assign qual = flag_reg & i_src_enable & {NUM_SRC{!mask}};
  assign take_hw = any_q && i_instr_done;
  assign take_sw = i_instr_done && (i_exec_trap || i_dbg_trap);

  cieu_prio_enc #(.N(NUM_SRC)) u_prio (
    .i_req(qual),
    .o_any(any_q),
    .o_idx(win_idx)
  );

  ////////////////////////////////////////////////////////////////////
  // source flags: set wins over clear
  always_ff @(posedge i_clk_sys or negedge i_nrst)
  begin
    if (!i_nrst)
      flag_reg <= '0;
    else
      flag_reg <= (flag_reg & ~i_src_flag_clr) | (i_src_event & i_src_enable);
  end

  ////////////////////////////////////////////////////////////////////
  // condition code
  always_ff @(posedge i_clk_sys or negedge i_nrst)
  begin
    if (!i_nrst)
      cond_reg <= cieu_pkg::COND_RESET;
    else if (state_reg == ST_PUSH && cnt_reg == 3'(cieu_pkg::STACK_BYTES - 1))
      cond_reg[cieu_pkg::COND_MASK_BIT] <= 1'b1;
    else if (state_reg == ST_RUN && i_exec_wait && !take_hw && !take_sw)
      cond_reg[cieu_pkg::COND_MASK_BIT] <= 1'b0;
    else if (state_reg == ST_RUN && i_cond_load)
      cond_reg <= i_cond_value;
  end

  ////////////////////////////////////////////////////////////////////
  // stacked byte order: pcl, pch, x, a, ccr
  always_comb
  begin
    case (cnt_reg)
      3'h0: push_byte = i_regs.pc[7:0];
      3'h1: push_byte = i_regs.pc[15:8];
      3'h2: push_byte = i_regs.x;
      3'h3: push_byte = i_regs.a;
      default: push_byte = cond_reg;
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // entry sequencer; hardware and software entry share one path
  always_ff @(posedge i_clk_sys or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      state_reg <= ST_RUN;
      cnt_reg <= '0;
      vec_reg <= '0;
    end
    else
    begin
      case (state_reg)
        ST_RUN:
        begin
          cnt_reg <= '0;
          if (take_hw || take_sw)
          begin
            state_reg <= ST_PUSH;
            vec_reg <= take_hw ? cieu_pkg::VEC_BASE - 16'({win_idx, 1'b0}) : cieu_pkg::VEC_TRAP;
          end
          else if (i_exec_wait)
            state_reg <= ST_WAIT_FREE;
        end
        ST_WAIT_FREE:
          state_reg <= ST_WAIT_FETCH;
        ST_WAIT_FETCH:
          state_reg <= ST_HALT;
        ST_HALT:
          if (any_q)
          begin
            state_reg <= ST_PUSH;
            vec_reg <= cieu_pkg::VEC_BASE - 16'({win_idx, 1'b0});
          end
        ST_PUSH:
        begin
          cnt_reg <= cnt_reg + 3'h1;
          if (cnt_reg == 3'(cieu_pkg::STACK_BYTES - 1))
          begin
            cnt_reg <= '0;
            state_reg <= ST_VEC_HI;
          end
        end
        ST_VEC_HI:
          state_reg <= ST_VEC_LO;
        ST_VEC_LO:
          state_reg <= ST_FILL;
        ST_FILL:
        begin
          cnt_reg <= cnt_reg + 3'h1;
          if (cnt_reg == 3'(cieu_pkg::QUEUE_BYTES - 1))
          begin
            cnt_reg <= '0;
            state_reg <= ST_RUN;
          end
        end
        default:
          state_reg <= ST_RUN;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // stack pointer, program counter and queue
  always_ff @(posedge i_clk_sys or negedge i_nrst)
  begin
    if (!i_nrst)
      sp_reg <= cieu_pkg::SP_RESET;
    else if (state_reg == ST_PUSH)
      sp_reg <= sp_reg - 16'h0001;
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      pc_reg <= '0;
      queue_reg <= '0;
    end
    else if (state_reg == ST_VEC_HI)
      pc_reg[15:8] <= i_rdata;
    else if (state_reg == ST_VEC_LO)
      pc_reg[7:0] <= i_rdata;
    else if (state_reg == ST_FILL)
    begin
      queue_reg <= {queue_reg[15:0], i_rdata};
      pc_reg <= pc_reg + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // bus cycle for the current state (combinational handshake)
  always_comb
  begin
    o_bus = '0;
    case (state_reg)
      ST_PUSH:
      begin
        o_bus.valid = 1'b1;
        o_bus.write = 1'b1;
        o_bus.addr = sp_reg;
        o_bus.wdata = push_byte;
      end
      ST_VEC_HI:
      begin
        o_bus.valid = 1'b1;
        o_bus.addr = vec_reg;
      end
      ST_VEC_LO:
      begin
        o_bus.valid = 1'b1;
        o_bus.addr = vec_reg + 16'h0001;
      end
      ST_FILL:
      begin
        o_bus.valid = 1'b1;
        o_bus.addr = pc_reg;
      end
      ST_WAIT_FREE:
      begin
        o_bus.valid = 1'b1;
        o_bus.free = 1'b1;
        o_bus.addr = i_regs.pc;
      end
      ST_WAIT_FETCH:
      begin
        o_bus.valid = 1'b1;
        o_bus.addr = i_regs.pc;
      end
      default:
        o_bus = '0;
    endcase
  end

  assign o_src_flag = flag_reg;
  assign o_condition_code_reg = cond_reg;
  assign o_sp = sp_reg;
  assign o_pc = pc_reg;
  assign o_queue = queue_reg;
  assign o_busy = state_reg != ST_RUN;
  assign o_halted = state_reg == ST_HALT;
  assign o_entry_done = state_reg == ST_FILL && cnt_reg == 3'(cieu_pkg::QUEUE_BYTES - 1);

  ////////////////////////////////////////////////////////////////////
  AST_MASK_BLOCKS: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    (state_reg == ST_RUN && mask && !i_exec_trap && !i_dbg_trap) |=> state_reg != ST_PUSH)
    else $error("entry started while masked");
  AST_WAIT_ACCEPT: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    (state_reg == ST_HALT && any_q) |=> state_reg == ST_PUSH)
    else $error("halt did not end on interrupt");
  AST_BOUNDARY: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    (state_reg == ST_RUN && $past(state_reg) == ST_RUN) ##1 state_reg == ST_PUSH |-> $past(i_instr_done))
    else $error("entry without instruction boundary");
  AST_PUSH_LEN: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    $rose(state_reg == ST_PUSH) |-> (state_reg == ST_PUSH)[*5] ##1 state_reg == ST_VEC_HI)
    else $error("wrong stacking length");
  AST_MASK_SET: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    state_reg == ST_VEC_HI |-> mask)
    else $error("mask not set after stacking");
  AST_FILL_LEN: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    $rose(state_reg == ST_FILL) |-> (o_bus.valid && !o_bus.write)[*3] ##1 state_reg == ST_RUN)
    else $error("queue fill not three reads");
  AST_FREE_ONE: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    o_bus.free |-> !o_bus.write ##1 !o_bus.free)
    else $error("free cycle too long or a write");
  AST_FLAG_SET: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    (i_src_event & i_src_enable) != '0 |=> (o_src_flag & $past(i_src_event & i_src_enable)) != '0)
    else $error("event flag lost");
  AST_COND_LOAD: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    (state_reg == ST_RUN && i_cond_load && !i_exec_wait) |=> cond_reg == $past(i_cond_value))
    else $error("condition code not restored");

  COV_HW: cover property (@(posedge i_clk_sys) disable iff (!i_nrst) take_hw ##1 state_reg == ST_PUSH);
  COV_DBG: cover property (@(posedge i_clk_sys) disable iff (!i_nrst) i_dbg_trap && i_instr_done);
  COV_WAIT: cover property (@(posedge i_clk_sys) disable iff (!i_nrst) state_reg == ST_HALT ##1 state_reg == ST_PUSH);
endmodule // cieu_entry

// ### verif/cieu_src_model.sv
`timescale 1ns/100ps
module cieu_src_model (
  input wire logic i_clk_sys,                // bus clock
  input wire logic [7:0] i_fire,             // bench request per source
  input wire cieu_pkg::cieu_bus_t i_bus,     // design bus cycle
  output logic [7:0] o_src_event,            // one-cycle source events
  output logic [7:0] o_rdata                 // read data, same cycle
);
  // launched on the rising edge: the bench writes i_fire on the falling edge, so no race there
  always @(posedge i_clk_sys)
  begin
    o_src_event <= i_fire;
  end
  // no read in progress: inverted address, never a stale byte
  assign o_rdata = (i_bus.valid && !i_bus.write) ? (i_bus.addr[7:0] ^ i_bus.addr[15:8] ^ 8'h3c) : ~i_bus.addr[7:0];
endmodule // cieu_src_model

// ### verif/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  logic i_clk_sys = 1'b0;
  logic i_nrst = 1'b0;
  logic [7:0] fire = 8'h00, en = 8'h00, clr = 8'h00, ev, rd, flag, cond, ldv = 8'h00, mflag;
  logic done = 1'b0, wt = 1'b0, trp = 1'b0, dbg = 1'b0, ld = 1'b0, busy, halted, edone;
  cieu_pkg::cieu_regs_t regs = '0;
  cieu_pkg::cieu_bus_t bus;
  logic [15:0] sp, pc, msp = 16'h00ff;
  logic [23:0] q;
  logic [7:0] mccr = 8'h68;
  logic [31:0] seed = 32'h7eb4;
  int failures = 0;
  int checks = 0;
  int w;
  always #4 i_clk_sys = ~i_clk_sys;
  cieu_entry cieu_entry_i (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_src_event(ev), .i_src_enable(en),
    .i_src_flag_clr(clr), .i_instr_done(done), .i_exec_wait(wt), .i_exec_trap(trp), .i_dbg_trap(dbg),
    .i_cond_load(ld), .i_cond_value(ldv), .i_regs(regs), .i_rdata(rd), .o_bus(bus), .o_src_flag(flag),
    .o_condition_code_reg(cond), .o_sp(sp), .o_pc(pc), .o_queue(q), .o_busy(busy), .o_halted(halted),
    .o_entry_done(edone));
  cieu_src_model cieu_src_model_i (.i_clk_sys(i_clk_sys), .i_fire(fire), .i_bus(bus), .o_src_event(ev),
    .o_rdata(rd));
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [7:0] mem(input logic [15:0] a);
    mem = a[7:0] ^ a[15:8] ^ 8'h3c;
  endfunction
  task automatic tally_and_finish;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      failures++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge i_clk_sys);
  endtask
  // one entry from its first push; the wait is bounded for the halted case
  task automatic entry(input logic [15:0] vec);
    logic [7:0] st [5];
    logic [15:0] p;
    int k;
    st = '{regs.pc[7:0], regs.pc[15:8], regs.x, regs.a, mccr};
    k = 0;
    while (!(bus.valid === 1'b1 && bus.write === 1'b1) && k < 20)
    begin
      tick(1);
      k++;
    end
    if (k == 20)
    begin
      failures++;
      tally_and_finish();
    end
    for (int i = 0; i < 5; i++)
    begin
      chk("push addr", 32'(msp - 16'(i)), 32'(bus.addr));
      chk("push data", 32'(st[i]), 32'(bus.wdata));
      tick(1);
    end
    mccr[3] = 1'b1;
    msp = msp - 16'h0005;
    for (int i = 0; i < 2; i++)
    begin
      chk("vector read", {16'h0000, vec + 16'(i)}, {15'h0000, bus.write, bus.addr});
      tick(1);
    end
    p = {mem(vec), mem(vec + 16'h0001)};
    for (int i = 0; i < 3; i++)
    begin
      chk("fill read", {16'h0000, p + 16'(i)}, {15'h0000, bus.write, bus.addr});
      chk("entry done", 32'(i == 2), 32'(edone));
      tick(1);
    end
    chk("queue", {8'h00, mem(p), mem(p + 16'h0001), mem(p + 16'h0002)}, 32'(q));
    chk("cond", 32'(mccr), 32'(cond));
    chk("pc", 32'(p + 16'h0003), 32'(pc));
    chk("sp", 32'(msp), 32'(sp));
    chk("busy", 32'h0, 32'(busy));
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    tick(20);
    i_nrst = 1'b1;
    chk("reset cond", 32'(cieu_pkg::COND_RESET), 32'(cond));
    chk("reset sp", 32'(cieu_pkg::SP_RESET), 32'(sp));
    en = 8'hfe;
    seed = lfsr(seed);
    fire = seed[7:0] | 8'h11;
    mflag = fire & en;
    tick(1);
    fire = 8'h00;
    tick(2);
    chk("flags", 32'(mflag), 32'(flag));
    done = 1'b1;
    tick(1);
    done = 1'b0;
    tick(2);
    chk("masked busy", 32'h0, 32'(busy));
    ld = 1'b1;
    ldv = 8'h60;
    tick(1);
    ld = 1'b0;
    mccr = 8'h60;
    tick(2);
    chk("no boundary busy", 32'h0, 32'(busy));
    while (mflag != 8'h00)
    begin
      w = 0;
      while (!mflag[w])
        w++;
      seed = lfsr(seed);
      regs = {seed[15:0], seed[31:8]};
      done = 1'b1;
      tick(1);
      done = 1'b0;
      entry(cieu_pkg::VEC_BASE - 16'(2 * w));
      clr = 8'h01 << w;
      ld = 1'b1;
      tick(1);
      clr = 8'h00;
      ld = 1'b0;
      mflag[w] = 1'b0;
      mccr = 8'h60;
      chk("restored mask", 32'h0, 32'(cond[3]));
      chk("flags cleared", 32'(mflag), 32'(flag));
    end
    for (int t = 0; t < 2; t++)
    begin
      trp = (t == 0);
      dbg = (t == 1);
      done = 1'b1;
      tick(1);
      {trp, dbg, done} = 3'b000;
      entry(cieu_pkg::VEC_TRAP);
    end
    wt = 1'b1;
    done = 1'b1;
    tick(1);
    {wt, done} = 2'b00;
    chk("free read", 32'h5, {29'h0, bus.valid, bus.write, bus.free});
    tick(1);
    chk("program read", 32'h4, {29'h0, bus.valid, bus.write, bus.free});
    tick(2);
    chk("halted", 32'h1, {30'h0, cond[3], halted});
    mccr[3] = 1'b0;
    fire = 8'h08;
    tick(1);
    fire = 8'h00;
    entry(cieu_pkg::VEC_BASE - 16'h0006);
    // second reset in mid-run: mask must come back set
    i_nrst = 1'b0;
    tick(2);
    i_nrst = 1'b1;
    chk("rereset cond", 32'(cieu_pkg::COND_RESET), 32'(cond));
    chk("rereset sp", 32'(cieu_pkg::SP_RESET), 32'(sp));
    chk("rereset busy", 32'h0, 32'(busy));
    tally_and_finish();
  end
endmodule // tb_top
